//--- logic/sde_pkg.sv
//****************************************************************
// Purpose: Constants and types of the descriptor engine
// Assumes: 16-bit shared memory words, 40 MHz clock
// Notes:   Notes on behaviour listed below
//****************************************************************
// Notes on behaviour
// - Fetch descriptor words for addressed subaddress
// - Function bits enable when one
// - Bit 10 illegalizes broadcast receive commands
// - Bit 9 illegalizes subaddress, illegal interrupt
// - Bit 8 interrupts before descriptor update
// - Bit 7 interrupts when index reaches zero
// - Index decrements per message, stops zero
// - Errored messages also decrement index
// - Status words at pointer, pointer plus one
// - Index zero holds status list pointer
// - Errored message still writes status word
// - Data words stored consecutively from pointer
// - Good message advances data list pointer
// - Errored message keeps data list pointer
// - Index zero keeps data list pointer
// - Fourth descriptor word never touched
// - Status bit 15 is subsystem fail
// - Status bit 14 marks broadcast message
// - Status bit 13 flags invalid message
// - Word count field; surplus dropped, short flagged
// - Time tag in 64 us steps
// - Receive, transmit descriptor per subaddress, sequential
// - Update order: status, data, status ptr, control
package sde_pkg;

  // ****************************************************
  // Memory and descriptor layout
  // ****************************************************
  localparam int AW          = 16;    // Memory address width
  localparam int DW          = 16;    // Memory data width
  localparam logic [1:0] OFF_CTL = 2'h0;  // Control word
  localparam logic [1:0] OFF_MSL = 2'h1;  // Status list pointer
  localparam logic [1:0] OFF_DLP = 2'h2;  // Data list pointer

  // Control word fields
  localparam int CW_ILL_BC   = 10;    // Illegal broadcast
  localparam int CW_ILL      = 9;     // Illegal subaddress
  localparam int CW_INT_CMD  = 8;     // Interrupt per command
  localparam int CW_INT_IDX  = 7;     // Interrupt at index zero
  localparam int IDX_W       = 7;     // Index width

  // Message status word fields
  localparam int SW_SSF      = 15;
  localparam int SW_BC       = 14;
  localparam int SW_ERR      = 13;
  localparam int WC_W        = 5;     // Word count field width
  localparam int TAG_W       = 8;     // Time tag width
  localparam logic [5:0] WC_FULL = 6'h20; // Count field zero = 32

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLK_MHZ     = 40;
  localparam int TAG_STEP_NS = 64000; // 64 us tag resolution
  localparam int TAG_CYC     = TAG_STEP_NS * CLK_MHZ / 1000;

  // ****************************************************
  // Register port map
  // ****************************************************
  localparam int RA_W              = 2;
  localparam logic [1:0] REG_CTRL  = 2'h0; // Control
  localparam logic [1:0] REG_STAT  = 2'h1; // Engine state
  localparam logic [1:0] REG_TTAG  = 2'h2; // Time tag
  localparam int CTRL_ILL_IE = 0;     // Illegal interrupt enable
  localparam int CTRL_SSF    = 1;     // Force subsystem fail

  // ****************************************************
  // Types
  // ****************************************************
  typedef struct packed {
    logic            valid;  // Command taken this cycle
    logic [4:0]      subaddr;
    logic            xmit;   // Transmit command
    logic            bcast;  // Broadcast command
    logic [WC_W-1:0] wcount; // Word count field
  } sde_cmd_t;

  typedef struct packed {
    logic          req;      // Access this cycle
    logic          we;       // Write
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } sde_mem_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_RD_CTL = 4'h1,
    ST_RD_MSL = 4'h2,
    ST_RD_DLP = 4'h3,
    ST_CHECK  = 4'h4,
    ST_XFER   = 4'h5,
    ST_NOTIFY = 4'h6,
    ST_WR_STS = 4'h7,
    ST_WR_DLP = 4'h8,
    ST_WR_MSL = 4'h9,
    ST_WR_CTL = 4'hA
  } sde_state_t;

endpackage : sde_pkg

//--- logic/sde_engine.sv
//****************************************************************
// Purpose: Remote terminal subaddress descriptor engine
// Assumes: Memory answers a read in the next cycle, never waits
// Notes:   All outputs are registered
//****************************************************************
//
// Chosen here: the register addresses and strobed register access.
module sde_engine #(
  parameter logic [15:0] DESC_BASE = 16'h0000 // Descriptor space
) (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire sde_pkg::sde_cmd_t       cmd,
  input  wire logic                    rx_valid,
  input  wire logic [sde_pkg::DW-1:0]  rx_data,
  input  wire logic                    tx_req,
  input  wire logic                    msg_done,
  input  wire logic                    msg_err,
  input  wire logic                    subsystem_fail_input,
  output sde_pkg::sde_mem_t            mem,
  input  wire logic [sde_pkg::DW-1:0]  mem_rdata,
  output logic                         tx_valid,
  output logic [sde_pkg::DW-1:0]       tx_data,
  output logic                         msg_error_bit,
  output logic                         int_cmd,
  output logic                         int_index,
  output logic                         int_illegal,
  output logic                         busy,
  input  wire logic [sde_pkg::RA_W-1:0] reg_addr,
  input  wire logic [sde_pkg::DW-1:0]  reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [sde_pkg::DW-1:0]       reg_rdata
);

  // ****************************************************
  // Elaboration check
  // ****************************************************
  if (DESC_BASE[6:0] != 7'h00) begin : g_chk
    $error("Descriptor base must be 128-word aligned");
  end

  // ****************************************************
  // Storage
  // ****************************************************
  sde_pkg::sde_state_t            state;     // Engine state
  sde_pkg::sde_cmd_t              cur;       // Command in service
  logic [sde_pkg::DW-1:0]         ctl;       // Control word
  logic [sde_pkg::AW-1:0]         msl;       // Status list pointer
  logic [sde_pkg::AW-1:0]         dlp;       // Data list pointer
  logic [sde_pkg::AW-1:0]         dbase;     // Descriptor address
  logic [5:0]                     cnt;       // Words seen
  logic                           err;       // Message invalid
  logic                           ssf_seen;  // Fail seen since status write
  logic                           rd_pend;   // Transmit read out
  logic [1:0]                     ctrl;      // Control register
  logic [sde_pkg::TAG_W-1:0]      ttag;      // Time tag
  logic [11:0]                    tdiv;      // Tag prescaler

  // ****************************************************
  // Decoding
  // ****************************************************
  // Word count with zero meaning thirty-two
  function automatic logic [5:0] full_wc(
    input logic [sde_pkg::WC_W-1:0] f);
    full_wc = (f == '0) ? sde_pkg::WC_FULL : {1'b0, f};
  endfunction : full_wc

  // Address of one word of the current descriptor
  function automatic logic [sde_pkg::AW-1:0] dword(
    input logic [sde_pkg::AW-1:0] b, input logic [1:0] o);
    dword = b | {14'h0000, o};
  endfunction : dword

  wire [5:0] wc_n = full_wc(cur.wcount);     // Expected count
  wire [6:0] idx  = ctl[sde_pkg::IDX_W-1:0]; // Current index
  wire       idx0 = (idx == 7'h00);
  wire ill_bc = ctl[sde_pkg::CW_ILL_BC] & cur.bcast & ~cur.xmit;
  wire ill = ctl[sde_pkg::CW_ILL] | ill_bc;
  wire err_now = err | msg_err | (cnt != wc_n);
  wire [6:0] next_idx = idx0 ? 7'h00 : idx - 7'h01;
  wire [sde_pkg::AW-1:0] next_msl =
    idx0 ? msl : msl + 16'h0001; // hold at zero
  wire [sde_pkg::AW-1:0] next_dlp =
    (err | idx0) ? dlp : dlp + {10'h000, wc_n}; // hold
  wire [sde_pkg::AW-1:0] cmd_base =
    DESC_BASE + {8'h00, cmd.subaddr, cmd.xmit, 2'b00};
  wire [sde_pkg::DW-1:0] status_word = {
    ssf_seen | ctrl[sde_pkg::CTRL_SSF], cur.bcast, err,
    cur.wcount, ttag};
  wire tag_tick = (tdiv == 12'(sde_pkg::TAG_CYC - 1));
  wire in_xfer  = (state == sde_sm_xfer());
  wire rx_store = in_xfer & rx_valid & ~cur.xmit & (cnt < wc_n);
  wire tx_fetch = in_xfer & tx_req & cur.xmit & (cnt < wc_n);
  wire rd_hit   = (reg_addr == sde_pkg::REG_CTRL) |
                  (reg_addr == sde_pkg::REG_STAT) |
                  (reg_addr == sde_pkg::REG_TTAG);

  function automatic sde_pkg::sde_state_t sde_sm_xfer();
    sde_sm_xfer = sde_pkg::ST_XFER;
  endfunction : sde_sm_xfer

  // ****************************************************
  // Next state and memory request
  // ****************************************************
  sde_pkg::sde_state_t next_state;
  sde_pkg::sde_mem_t   next_mem;

  // Sequencer: descriptor fetch, transfer, update burst
  always_comb begin
    next_state = state;
    next_mem   = '0;
    unique case (state)
      sde_pkg::ST_IDLE: begin
        if (cmd.valid) begin
          next_mem   = '{1'b1, 1'b0,
                         dword(cmd_base, sde_pkg::OFF_CTL), '0};
          next_state = sde_pkg::ST_RD_CTL;
        end
      end
      sde_pkg::ST_RD_CTL: begin
        next_mem   = '{1'b1, 1'b0,
                       dword(dbase, sde_pkg::OFF_MSL), '0};
        next_state = sde_pkg::ST_RD_MSL;
      end
      sde_pkg::ST_RD_MSL: begin
        next_mem   = '{1'b1, 1'b0,
                       dword(dbase, sde_pkg::OFF_DLP), '0};
        next_state = sde_pkg::ST_RD_DLP;
      end
      sde_pkg::ST_RD_DLP: begin
        next_state = sde_pkg::ST_CHECK;
      end
      sde_pkg::ST_CHECK: begin
        next_state = ill ? sde_pkg::ST_IDLE : sde_pkg::ST_XFER;
      end
      sde_pkg::ST_XFER: begin
        if (rx_store) begin
          next_mem = '{1'b1, 1'b1, dlp + {10'h000, cnt}, rx_data};
        end else if (tx_fetch) begin
          next_mem = '{1'b1, 1'b0, dlp + {10'h000, cnt}, '0};
        end
        if (msg_done) begin
          next_state = sde_pkg::ST_NOTIFY;
        end
      end
      sde_pkg::ST_NOTIFY: begin
        // status word first, even on error
        next_mem   = '{1'b1, 1'b1, msl, status_word};
        next_state = sde_pkg::ST_WR_STS;
      end
      sde_pkg::ST_WR_STS: begin
        next_mem   = '{1'b1, 1'b1,
                       dword(dbase, sde_pkg::OFF_DLP), next_dlp};
        next_state = sde_pkg::ST_WR_DLP;
      end
      sde_pkg::ST_WR_DLP: begin
        next_mem   = '{1'b1, 1'b1,
                       dword(dbase, sde_pkg::OFF_MSL), next_msl};
        next_state = sde_pkg::ST_WR_MSL;
      end
      sde_pkg::ST_WR_MSL: begin
        next_mem   = '{1'b1, 1'b1, dword(dbase, sde_pkg::OFF_CTL),
                       {ctl[15:7], next_idx}};
        next_state = sde_pkg::ST_WR_CTL;
      end
      sde_pkg::ST_WR_CTL: begin
        next_state = sde_pkg::ST_IDLE;
      end
      default: begin
        next_state = sde_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************************************
  // Sequencer registers
  // ****************************************************
  // State and memory port
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= sde_pkg::ST_IDLE;
      mem   <= '0;
      busy  <= 1'b0;
    end else begin
      state <= next_state;
      mem   <= next_mem;
      busy  <= (next_state != sde_pkg::ST_IDLE);
    end
  end

  // Command and descriptor capture
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur   <= '0;
      dbase <= '0;
      ctl   <= '0;
      msl   <= '0;
      dlp   <= '0;
    end else begin
      if (state == sde_pkg::ST_IDLE && cmd.valid) begin
        cur   <= cmd;
        dbase <= cmd_base;
      end
      if (state == sde_pkg::ST_RD_MSL) ctl <= mem_rdata;
      if (state == sde_pkg::ST_RD_DLP) msl <= mem_rdata;
      if (state == sde_pkg::ST_CHECK)  dlp <= mem_rdata;
    end
  end

  // Word counting and error accumulation
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      err <= 1'b0;
    end else if (state == sde_pkg::ST_CHECK) begin
      cnt <= '0;
      err <= 1'b0;
    end else if (in_xfer) begin
      if ((rx_valid & ~cur.xmit) | (tx_req & cur.xmit)) begin
        cnt <= (cnt == 6'h3F) ? cnt : cnt + 6'h01;
      end
      if (msg_done) err <= err_now;
    end
  end

  // Subsystem fail seen since the last status write; set beats clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ssf_seen <= 1'b0;
    end else if (subsystem_fail_input) begin
      ssf_seen <= 1'b1;
    end else if (state == sde_pkg::ST_WR_STS) begin
      ssf_seen <= 1'b0;
    end
  end

  // Transmit data return, two cycles after the read
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_pend  <= 1'b0;
      tx_valid <= 1'b0;
      tx_data  <= '0;
    end else begin
      rd_pend  <= mem.req & ~mem.we & in_xfer;
      tx_valid <= rd_pend;
      if (rd_pend) tx_data <= mem_rdata;
    end
  end

  // Message error bit and interrupt pulses
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      msg_error_bit <= 1'b0;
      int_cmd       <= 1'b0;
      int_index     <= 1'b0;
      int_illegal   <= 1'b0;
    end else begin
      if (state == sde_pkg::ST_IDLE && cmd.valid) begin
        msg_error_bit <= 1'b0;
      end else if (state == sde_pkg::ST_CHECK && ill) begin
        msg_error_bit <= 1'b1;
      end else if (in_xfer && msg_done && cnt < wc_n) begin
        msg_error_bit <= 1'b1;
      end
      int_illegal <= (state == sde_pkg::ST_CHECK) &
                     ctl[sde_pkg::CW_ILL] &
                     ctrl[sde_pkg::CTRL_ILL_IE];
      int_cmd <= in_xfer & msg_done & ctl[sde_pkg::CW_INT_CMD];
      int_index <= (state == sde_pkg::ST_WR_MSL) &
                   ctl[sde_pkg::CW_INT_IDX] & (idx == 7'h01);
    end
  end

  // ****************************************************
  // Time tag
  // ****************************************************
  // free counter in 64 us steps, wraps
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tdiv <= '0;
      ttag <= '0;
    end else begin
      tdiv <= tag_tick ? 12'h000 : tdiv + 12'h001;
      if (tag_tick) ttag <= ttag + 8'h01;
    end
  end

  // ****************************************************
  // Register port
  // ****************************************************
  // Control write and one-cycle read answer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl      <= '0;
      reg_rdata <= '0;
    end else begin
      if (reg_wr && reg_addr == sde_pkg::REG_CTRL) begin
        ctrl <= reg_wdata[1:0];
      end
      if (reg_rd && rd_hit) begin
        unique case (reg_addr)
          sde_pkg::REG_CTRL: reg_rdata <= {14'h0000, ctrl};
          sde_pkg::REG_STAT: reg_rdata <=
            {10'h000, msg_error_bit, busy, state};
          default:           reg_rdata <= {8'h00, ttag};
        endcase
      end else begin
        reg_rdata <= '0;
      end
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_ill;
    state == sde_pkg::ST_CHECK && ctl[sde_pkg::CW_ILL]
      |=> msg_error_bit && state == sde_pkg::ST_IDLE
      ##1 !mem.req;
  endproperty
  a_ill: assert property (p_ill)
    else $error("Illegal subaddress not refused");

  property p_bc;
    state == sde_pkg::ST_CHECK && ctl[sde_pkg::CW_ILL_BC] &&
    cur.bcast && !cur.xmit |=> msg_error_bit;
  endproperty
  a_bc: assert property (p_bc)
    else $error("Broadcast illegal not flagged");

  property p_intcmd;
    state == sde_pkg::ST_NOTIFY |->
      int_cmd == ctl[sde_pkg::CW_INT_CMD] ##1 !int_cmd;
  endproperty
  a_intcmd: assert property (p_intcmd)
    else $error("Command interrupt misplaced");

  property p_order;
    state == sde_pkg::ST_WR_STS |-> mem.addr == msl ##1
      mem.addr == dword(dbase, sde_pkg::OFF_DLP) ##1
      mem.addr == dword(dbase, sde_pkg::OFF_MSL) ##1
      mem.addr == dword(dbase, sde_pkg::OFF_CTL);
  endproperty
  a_order: assert property (p_order)
    else $error("Update burst out of order");

  property p_idx;
    state == sde_pkg::ST_WR_CTL |-> mem.wdata[6:0] ==
      ((idx == 7'h00) ? 7'h00 : idx - 7'h01);
  endproperty
  a_idx: assert property (p_idx)
    else $error("Index update wrong");

  property p_msl;
    state == sde_pkg::ST_WR_MSL |->
      mem.wdata == msl + {15'h0000, !idx0};
  endproperty
  a_msl: assert property (p_msl)
    else $error("Status pointer update wrong");

  property p_dlp;
    state == sde_pkg::ST_WR_DLP && (err || idx0) |->
      mem.wdata == dlp;
  endproperty
  a_dlp: assert property (p_dlp)
    else $error("Data pointer moved on error");

  property p_ssf;
    state == sde_pkg::ST_WR_STS && ctrl[sde_pkg::CTRL_SSF] |->
      mem.wdata[sde_pkg::SW_SSF];
  endproperty
  a_ssf: assert property (p_ssf)
    else $error("Subsystem fail bit missing");

  property p_tag;
    tag_tick |=> ttag == 8'($past(ttag) + 8'h01);
  endproperty
  a_tag: assert property (p_tag)
    else $error("Time tag did not step");

endmodule : sde_engine

//--- dv/sde_mem_model.sv
// Purpose: Shared memory seen by the descriptor engine
// Assumes: Reads answer next cycle, the engine never waits
// Notes:   Idle read data flips each cycle, never holds a stale word
module sde_mem_model (
  input  wire sde_pkg::sde_mem_t mem,
  input  wire logic              clock,
  output logic [15:0]            mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] ram [0:1023];   // Descriptors and lists
  logic [15:0] rd_word = 16'h0; // Word on the read bus
  // ****************************************
  // Access port
  // ****************************************
  // descriptors in sequence
  // Flat word array, receive descriptor at base plus subaddress times eight, transmit four words on
  always @(posedge clock) begin
    if (mem.req & mem.we) begin
      ram[mem.addr[9:0]] <= mem.wdata;
    end
    // Released bus shows a changing pattern
    if (mem.req & ~mem.we) begin
      rd_word <= ram[mem.addr[9:0]];
    end else begin
      rd_word <= ~rd_word;
    end
  end
  assign mem_rdata = rd_word;
endmodule : sde_mem_model

//--- dv/sde_engine_tb_top.sv
// Purpose: Self-checking bench of the descriptor engine
// Assumes: Host prepares descriptors straight in the memory model
// Notes:   One long idle stretch lets the time tag step once
module sde_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst = 1'b1;
  sde_pkg::sde_cmd_t cmd = '0;
  sde_pkg::sde_mem_t mem;
  logic rx_valid = 0, tx_req = 0, msg_done = 0, msg_err = 0, ssf = 0;
  logic reg_wr = 0, reg_rd = 0, tx_valid, err_bit, i_cmd, i_idx, i_ill;
  logic busy;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] rx_data = 0, reg_wdata = 0, mem_rdata, tx_data, reg_rdata;
  logic [15:0] q;              // Register read result
  logic [15:0] tx_q [$];       // Words handed out for transmit
  int num_errors = 0, check_count = 0, cycles = 0;
  int n_cmd = 0, n_idx = 0, n_ill = 0; // Interrupt pulse counts
  // ****************************************
  // Clock, timeout and monitors
  // ****************************************
  always #12.5 clock = ~clock;
  // Monitors sample at the falling edge, clear of the drive edge
  always @(negedge clock) begin
    cycles <= cycles + 1;
    if (tx_valid === 1'b1) tx_q.push_back(tx_data);
    if (i_cmd === 1'b1) n_cmd <= n_cmd + 1;
    if (i_idx === 1'b1) n_idx <= n_idx + 1;
    if (i_ill === 1'b1) n_ill <= n_ill + 1;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  sde_engine sde_engine_i (.clock(clock), .rst(rst), .cmd(cmd),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_req(tx_req),
    .msg_done(msg_done), .msg_err(msg_err), .subsystem_fail_input(ssf),
    .mem(mem), .mem_rdata(mem_rdata), .tx_valid(tx_valid),
    .tx_data(tx_data), .msg_error_bit(err_bit), .int_cmd(i_cmd),
    .int_index(i_idx), .int_illegal(i_ill), .busy(busy),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  sde_mem_model sde_mem_model_i (.mem(mem), .clock(clock),
    .mem_rdata(mem_rdata));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One register cycle, read data taken in the cycle after
  task automatic reg_op(input logic wr, input logic [1:0] a,
                        input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= ~wr;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
    @(posedge clock);
  endtask : reg_op
  // Host prepares a descriptor, fourth word carries a marker
  task automatic desc(input int b, input logic [15:0] c, m, d);
    sde_mem_model_i.ram[b] = c;
    sde_mem_model_i.ram[b+1] = m;
    sde_mem_model_i.ram[b+2] = d;
    sde_mem_model_i.ram[b+3] = 16'h5A5A;
  endtask : desc
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (busy !== 1'b0 && k < 100);
    check({15'h0, busy}, 16'h0);
    @(posedge clock);
  endtask : wait_idle
  // Command, n data words, then the end of message
  task automatic msg(input logic [4:0] sa, input logic xm, bc,
                     input logic [4:0] wc, input int n, input logic er,
                     input logic [15:0] s);
    cmd <= '{1'b1, sa, xm, bc, wc};
    @(posedge clock);
    cmd.valid <= 1'b0;
    repeat (8) @(posedge clock);
    for (int k = 0; k < n; k++) begin
      rx_valid <= ~xm;
      tx_req <= xm;
      rx_data <= s + 16'(k);
      @(posedge clock);
      rx_valid <= 1'b0;
      tx_req <= 1'b0;
      repeat (3) @(posedge clock);
    end
    msg_done <= 1'b1;
    msg_err <= er;
    @(posedge clock);
    msg_done <= 1'b0;
    msg_err <= 1'b0;
    wait_idle();
  endtask : msg
  // Descriptor words after a message: status top, msl, dlp, control
  task automatic after(input int b, m, input logic [7:0] st,
                       input logic [15:0] nm, nd, nc);
    check({8'h0, sde_mem_model_i.ram[m][15:8]}, {8'h0, st});
    check(sde_mem_model_i.ram[b+1], nm);
    check(sde_mem_model_i.ram[b+2], nd);
    check(sde_mem_model_i.ram[b], nc);
    check(sde_mem_model_i.ram[b+3], 16'h5A5A);
  endtask : after
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    reg_op(1'b1, 2'h0, 16'h0001);
    reg_op(1'b0, 2'h0, 16'h0);
    check(q, 16'h0001);
    reg_op(1'b0, 2'h3, 16'h0);
    check(q, 16'h0000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_rx();
    desc(8, 16'h0102, 16'd200, 16'd300);
    msg(5'd1, 1'b0, 1'b0, 5'd3, 3, 1'b0, 16'hA000);
    for (int k = 0; k < 3; k++)
      check(sde_mem_model_i.ram[300+k], 16'hA000 + 16'(k));
    after(8, 200, 8'h03, 16'd201, 16'd303, 16'h0101);
    check(16'(n_cmd), 16'd1);
    sde_mem_model_i.ram[8] = 16'h0081;
    msg(5'd1, 1'b0, 1'b0, 5'd2, 2, 1'b0, 16'hB000);
    check(16'(n_idx), 16'd1);
    after(8, 201, 8'h02, 16'd202, 16'd305, 16'h0080);
    msg(5'd1, 1'b0, 1'b0, 5'd2, 2, 1'b0, 16'hC000);
    after(8, 202, 8'h02, 16'd202, 16'd305, 16'h0080);
    check(sde_mem_model_i.ram[305], 16'hC000);
    check(16'(n_idx), 16'd1);
    $display("test receive done");
  endtask : t_rx
  task automatic t_err();
    desc(16, 16'h0003, 16'd210, 16'd320);
    msg(5'd2, 1'b0, 1'b0, 5'd2, 2, 1'b1, 16'hD000);
    after(16, 210, 8'h22, 16'd211, 16'd320, 16'h0002);
    desc(24, 16'h0005, 16'd220, 16'd340);
    msg(5'd3, 1'b0, 1'b0, 5'd4, 2, 1'b0, 16'hE000);
    check({15'h0, err_bit}, 16'h1);
    after(24, 220, 8'h24, 16'd221, 16'd340, 16'h0004);
    desc(32, 16'h0005, 16'd230, 16'd360);
    sde_mem_model_i.ram[361] = 16'h1111;
    msg(5'd4, 1'b0, 1'b0, 5'd1, 2, 1'b0, 16'hF000);
    check(sde_mem_model_i.ram[361], 16'h1111);
    check({15'h0, sde_mem_model_i.ram[230][13]}, 16'h1);
    $display("test errors done");
  endtask : t_err
  task automatic t_ill();
    desc(40, 16'h0205, 16'd240, 16'd380);
    cmd <= '{1'b1, 5'd5, 1'b0, 1'b0, 5'd1};
    @(posedge clock);
    cmd.valid <= 1'b0;
    wait_idle();
    check({15'h0, err_bit}, 16'h1);
    check(16'(n_ill), 16'd1);
    reg_op(1'b0, 2'h1, 16'h0);
    check(q, 16'h0020);
    check(sde_mem_model_i.ram[40], 16'h0205);
    desc(48, 16'h0405, 16'd250, 16'd390);
    cmd <= '{1'b1, 5'd6, 1'b0, 1'b1, 5'd1};
    @(posedge clock);
    cmd.valid <= 1'b0;
    wait_idle();
    check({15'h0, err_bit}, 16'h1);
    desc(52, 16'h0405, 16'd260, 16'd400);
    sde_mem_model_i.ram[400] = 16'h1234;
    sde_mem_model_i.ram[401] = 16'h5678;
    tx_q.delete();
    msg(5'd6, 1'b1, 1'b1, 5'd2, 2, 1'b0, 16'h0);
    check({15'h0, err_bit}, 16'h0);
    check(tx_q.size() > 1 ? tx_q[0] : 16'hFFFF, 16'h1234);
    check(tx_q.size() > 1 ? tx_q[1] : 16'hFFFF, 16'h5678);
    after(52, 260, 8'h42, 16'd261, 16'd402, 16'h0404);
    $display("test illegal and transmit done");
  endtask : t_ill
  task automatic t_ssf();
    desc(56, 16'h0005, 16'd270, 16'd420);
    ssf <= 1'b1;
    @(posedge clock);
    ssf <= 1'b0;
    msg(5'd7, 1'b0, 1'b0, 5'd1, 1, 1'b0, 16'h0);
    check({15'h0, sde_mem_model_i.ram[270][15]}, 16'h1);
    reg_op(1'b1, 2'h0, 16'h0002);
    repeat (2600) @(posedge clock);
    msg(5'd7, 1'b0, 1'b0, 5'd1, 1, 1'b0, 16'h0);
    check({15'h0, sde_mem_model_i.ram[271][15]}, 16'h1);
    check({8'h0, sde_mem_model_i.ram[271][7:0]}, 16'h0001);
    reg_op(1'b0, 2'h2, 16'h0);
    check(q, 16'h0001);
    $display("test subsystem fail done");
  endtask : t_ssf
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_rx();
    t_err();
    t_ill();
    t_ssf();
    report_and_stop();
  end
endmodule : sde_engine_tb_top
